// ### logic/fpn_programmer.sv
// fpn_programmer.sv - reads and programs one 4-bit word of a 256-word fuse PROM.
// assumes a control side that starts one operation at a time and a PROM socket
// whose outputs are sampled synchronously to clk.
// Function
// - nibble choice high picks write bits 4-7
// - bit index selects write bit, active low
// - position decoder drives exactly matching line high
// - sense rise retriggers 100 us burn-done timer
// - read phase routes indexed PROM bit to sense
// - read returns complemented word in both nibbles
// - pulse supply reaches only the selected output
// - three entry points: read, program high, low
// - range fault aborts first with address error
// - range fault when top four address bits nonzero
// - program bits zero through three in order
// - equal bits advance without any pulsing
// - want 0 but fuse 1 gives error
// - want 1 over 0 raises program phase
// - half duty pulses, width ramps 1 to 8 us
// - burn done drops phase, next bit follows
// - 400 ms timeout drops phase, pause, retry
// - eight failed attempts give failure-to-program error
// - in program phase sense stays low once fuse has blown
`timescale 1ns/1ps
`include "fpn_consts.svh"
module fpn_programmer
	import fpn_pkg::*;
#(
	parameter int BURN_TMO_CYC  = `FPN_BURN_TMO_CYC,
	parameter int PAUSE_CYC     = `FPN_PAUSE_CYC,
	parameter int RAMP_STEP_CYC = `FPN_RAMP_STEP_CYC
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// control side request
	input  wire logic         op_start,
	input  wire fpn_op_type   op_kind,
	input  wire logic [11:0]  prom_addr,
	input  wire logic [7:0]   write_data,
	// control side answer
	output logic              busy,
	output logic              op_done,
	output fpn_res_type       outcome,
	output logic [7:0]        read_data_n,
	output logic              range_fault,
	// card internal signals visible to the control side
	output logic              write_bit_n,
	output logic [1:0]        bit_index,
	output logic [3:0]        bit_position,
	output logic              program_phase,
	output logic              fuse_sense,
	output logic              burn_done_n,
	// PROM socket
	output logic [7:0]        socket_addr,
	input  wire logic [3:0]   prom_dout,
	output logic              pulse_supply,
	output logic              chip_disable_pulse,
	output logic [3:0]        drive_bits
);

	// counts must fit the counter fields that hold them, and a burn attempt
	// must outlast the one-shot or no bit could ever be reported done
	if (BURN_TMO_CYC < 1 || BURN_TMO_CYC >= (1 << `FPN_TMR_W) ||
	    PAUSE_CYC < 1 || PAUSE_CYC >= (1 << `FPN_TMR_W) ||
	    RAMP_STEP_CYC < 1 || RAMP_STEP_CYC >= (1 << `FPN_RAMP_W) ||
	    BURN_TMO_CYC <= `FPN_ONESHOT_CYC) begin : g_chk
		$error("fpn_programmer: timing parameter out of range");
	end

	localparam logic [`FPN_PW_W-1:0]   PW_MIN  = `FPN_PW_W'(`FPN_PW_MIN_CYC);
	localparam logic [`FPN_PW_W-1:0]   PW_MAX  = `FPN_PW_W'(`FPN_PW_MAX_CYC);
	localparam logic [`FPN_OS_W-1:0]   OS_CYC  = `FPN_OS_W'(`FPN_ONESHOT_CYC);
	localparam logic [`FPN_TMR_W-1:0]  TMO_END = `FPN_TMR_W'(BURN_TMO_CYC - 1);
	localparam logic [`FPN_TMR_W-1:0]  PAU_END = `FPN_TMR_W'(PAUSE_CYC - 1);
	localparam logic [`FPN_RAMP_W-1:0] RMP_END = `FPN_RAMP_W'(RAMP_STEP_CYC - 1);
	localparam logic [`FPN_TRY_W-1:0]  TRY_LAST = `FPN_TRY_W'(`FPN_MAX_TRIES - 1);

	// one write bit of the chosen nibble
	function automatic logic nib_bit(input logic [7:0] wd, input logic hi,
	                                 input logic [1:0] idx);
		logic [2:0] pos;
		pos = {hi, idx};
		return wd[pos];
	endfunction : nib_bit

	// two-bit index to one-hot line
	function automatic logic [3:0] one_hot(input logic [1:0] idx);
		return 4'h1 << idx;
	endfunction : one_hot

	fpn_state_type s_q;
	fpn_state_type s_d;
	logic          hi_nib;
	logic          want_one;
	logic          sense_rise;

	// card datapath, all decoded from registered state and synchronous inputs
	assign range_fault  = |prom_addr[`FPN_RANGE_MSB:`FPN_RANGE_LSB];
	assign hi_nib       = (s_q.op == OP_PROG_HI);
	assign write_bit_n  = ~nib_bit(write_data, hi_nib, s_q.idx);
	assign want_one     = ~write_bit_n;
	assign bit_index    = s_q.idx;
	assign bit_position = one_hot(s_q.idx);
	// between pulses an intact fuse pulls the output low and sense rises;
	// a blown fuse keeps the output high so sense stays low
	assign fuse_sense   = s_q.phase ? (~s_q.pon & ~prom_dout[s_q.idx])
	                                : prom_dout[s_q.idx];
	assign sense_rise   = fuse_sense & ~s_q.sense_q;
	assign program_phase      = s_q.phase;
	assign pulse_supply       = s_q.pon;
	assign chip_disable_pulse = s_q.pon;
	assign drive_bits   = bit_position & {4{s_q.phase & s_q.pon}};
	// fired lingers one edge after the phase drops; the output must not
	assign burn_done_n  = ~(s_q.fired & s_q.phase);
	assign socket_addr  = prom_addr[7:0];
	assign busy         = (s_q.st != ST_IDLE);
	assign op_done      = s_q.done;
	assign outcome      = s_q.res;
	assign read_data_n  = s_q.rd_data_n;

	// next state of the whole card
	always_comb begin
		s_d         = s_q;
		s_d.done    = 1'b0;
		s_d.sense_q = fuse_sense;
		// fuse-complete one-shot, only alive while programming
		if (!s_q.phase) begin
			s_d.armed  = 1'b0;
			s_d.fired  = 1'b0;
			s_d.os_cnt = '0;
		end else if (sense_rise) begin
			s_d.armed  = 1'b1;
			s_d.fired  = 1'b0;
			s_d.os_cnt = OS_CYC - `FPN_OS_W'(1);
		end else if (s_q.armed && s_q.os_cnt != '0) begin
			s_d.os_cnt = s_q.os_cnt - `FPN_OS_W'(1);
		end else if (s_q.armed) begin
			s_d.fired  = 1'b1;
		end
		case (s_q.st)
			ST_IDLE: begin
				// an unknown operation code is ignored
				if (op_start && op_kind != OP_NONE) begin
					s_d.op    = op_kind;
					s_d.idx   = 2'h0;
					s_d.tries = '0;
					s_d.st    = ST_CHECK;
				end
			end
			ST_CHECK: begin
				if (range_fault) begin
					s_d.res  = RES_ADDR_ERR;
					s_d.done = 1'b1;
					s_d.st   = ST_IDLE;
				end else if (s_q.op == OP_READ) begin
					s_d.st = ST_READ;
				end else begin
					s_d.st = ST_CMP;
				end
			end
			ST_READ: begin
				s_d.rd_data_n = {~prom_dout, ~prom_dout};
				s_d.res       = RES_OK;
				s_d.done      = 1'b1;
				s_d.st        = ST_IDLE;
			end
			ST_CMP: begin
				if (want_one == fuse_sense) begin
					s_d.tries = '0;
					if (s_q.idx == 2'h3) begin
						s_d.res  = RES_OK;
						s_d.done = 1'b1;
						s_d.st   = ST_IDLE;
					end else begin
						s_d.idx = s_q.idx + 2'h1;
					end
				end else if (!want_one) begin
					s_d.res  = RES_CONFLICT;
					s_d.done = 1'b1;
					s_d.st   = ST_IDLE;
				end else begin
					s_d.phase = 1'b1;
					s_d.pon   = 1'b1;
					s_d.width = PW_MIN;
					s_d.pcnt  = '0;
					s_d.rcnt  = '0;
					s_d.tmr   = '0;
					s_d.st    = ST_BURN;
				end
			end
			ST_BURN: begin
				// equal on and off halves; width grows one cycle per ramp step
				if (s_q.pcnt == s_q.width - `FPN_PW_W'(1)) begin
					s_d.pcnt = '0;
					s_d.pon  = ~s_q.pon;
				end else begin
					s_d.pcnt = s_q.pcnt + `FPN_PW_W'(1);
				end
				// a due step waits at the end count for the next half boundary,
				// so a step can come up to one half late while a half keeps one width
				if (s_q.rcnt == RMP_END) begin
					if (s_q.pcnt == '0) begin
						s_d.rcnt = '0;
						if (s_q.width < PW_MAX)
							s_d.width = s_q.width + `FPN_PW_W'(1);
					end
				end else begin
					s_d.rcnt = s_q.rcnt + `FPN_RAMP_W'(1);
				end
				s_d.tmr = s_q.tmr + `FPN_TMR_W'(1);
				if (s_q.fired) begin
					s_d.phase = 1'b0;
					s_d.pon   = 1'b0;
					s_d.tries = '0;
					if (s_q.idx == 2'h3) begin
						s_d.res  = RES_OK;
						s_d.done = 1'b1;
						s_d.st   = ST_IDLE;
					end else begin
						s_d.idx = s_q.idx + 2'h1;
						s_d.st  = ST_CMP;
					end
				end else if (s_q.tmr == TMO_END) begin
					s_d.phase = 1'b0;
					s_d.pon   = 1'b0;
					s_d.tmr   = '0;
					if (s_q.tries == TRY_LAST) begin
						s_d.res  = RES_NO_PROG;
						s_d.done = 1'b1;
						s_d.st   = ST_IDLE;
					end else begin
						s_d.tries = s_q.tries + `FPN_TRY_W'(1);
						s_d.st    = ST_PAUSE;
					end
				end
			end
			ST_PAUSE: begin
				// lets the pulse timing network discharge before the retry
				if (s_q.tmr == PAU_END) begin
					s_d.phase = 1'b1;
					s_d.pon   = 1'b1;
					s_d.width = PW_MIN;
					s_d.pcnt  = '0;
					s_d.rcnt  = '0;
					s_d.tmr   = '0;
					s_d.st    = ST_BURN;
				end else begin
					s_d.tmr = s_q.tmr + `FPN_TMR_W'(1);
				end
			end
			default: s_d.st = ST_IDLE;
		endcase
	end

	// state register; read data idles at all ones, the inactive level
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q           <= '0;
			s_q.st        <= ST_IDLE;
			s_q.op        <= OP_READ;
			s_q.res       <= RES_OK;
			s_q.rd_data_n <= 8'hff;
		end else begin
			s_q <= s_d;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence seq_pulse_start;
		s_q.st == ST_CMP && want_one && !fuse_sense;
	endsequence
	sequence seq_burn_seen;
		s_q.st == ST_BURN && !burn_done_n;
	endsequence

	a_nibble_pick: assert property (write_bit_n != write_data[{hi_nib, bit_index}])
		else $error("write bit does not follow nibble and index");
	a_onehot_pos: assert property ($onehot(bit_position) && bit_position[bit_index])
		else $error("bit position lines not one-hot at index");
	a_addr_abort: assert property (s_q.st == ST_CHECK && range_fault |=>
		op_done && outcome == RES_ADDR_ERR && !busy)
		else $error("range fault did not abort with address error");
	a_read_dup: assert property (s_q.st == ST_READ |=> op_done &&
		read_data_n == {~$past(prom_dout), ~$past(prom_dout)})
		else $error("read word not complemented into both nibbles");
	a_drive_only: assert property ((drive_bits & ~bit_position) == 4'h0 &&
		(program_phase || drive_bits == 4'h0))
		else $error("pulse reaches an unselected output");
	a_oneshot_hold: assert property (program_phase && sense_rise |=> burn_done_n [*8])
		else $error("burn done too soon after sense retrigger");
	a_burn_drop: assert property (seq_burn_seen |=> !program_phase)
		else $error("program phase stays high after burn done");
	a_conflict_err: assert property (s_q.st == ST_CMP && !want_one && fuse_sense |=>
		op_done && outcome == RES_CONFLICT)
		else $error("overwrite conflict not reported");
	a_phase_rise: assert property (seq_pulse_start |=> $rose(program_phase) ##1
		program_phase)
		else $error("program phase not raised for a needed bit");
	a_pulse_width: assert property ($rose(pulse_supply) && program_phase |->
		s_q.width >= PW_MIN && s_q.width <= PW_MAX)
		else $error("pulse width outside ramp limits");
	a_start_bit: assert property ($rose(busy) |-> bit_index == 2'h0)
		else $error("operation does not start at bit zero");
	a_retry_fail: assert property (s_q.st == ST_BURN && s_q.tmr == TMO_END && !s_q.fired
		&& s_q.tries == TRY_LAST |=> op_done && outcome == RES_NO_PROG)
		else $error("eighth failed attempt not reported");
	a_timeout_drop: assert property (s_q.st == ST_BURN && s_q.tmr == TMO_END && !s_q.fired |=>
		!program_phase)
		else $error("program phase stays high after burn timeout");
	a_equal_skip: assert property (s_q.st == ST_CMP && want_one == fuse_sense |=>
		!program_phase)
		else $error("pulse started for a bit already equal");

endmodule : fpn_programmer

// ### common/fpn_consts.svh
// fpn_consts.svh - offsets-free constants for the fuse nibble programmer:
// timing figures in their own units, derived cycle counts and field widths.
// assumes the block clock runs at the rate given by FPN_CLK_NS.
`ifndef FPN_CONSTS_SVH
`define FPN_CONSTS_SVH

`define FPN_CLK_NS          100
`define FPN_ONESHOT_US      100
`define FPN_PW_MIN_US       1
`define FPN_PW_MAX_US       8
`define FPN_RAMP_MS         100
`define FPN_BURN_TMO_MS     400
`define FPN_PAUSE_MS        4
`define FPN_MAX_TRIES       8

// cycle counts; a longest time rounds down, a least time rounds up
`define FPN_ONESHOT_CYC     ((`FPN_ONESHOT_US * 1000) / `FPN_CLK_NS)
`define FPN_PW_MIN_CYC      ((`FPN_PW_MIN_US * 1000 + `FPN_CLK_NS - 1) / `FPN_CLK_NS)
`define FPN_PW_MAX_CYC      ((`FPN_PW_MAX_US * 1000) / `FPN_CLK_NS)
`define FPN_BURN_TMO_CYC    ((`FPN_BURN_TMO_MS * 1000000) / `FPN_CLK_NS)
`define FPN_PAUSE_CYC       ((`FPN_PAUSE_MS * 1000000) / `FPN_CLK_NS)
`define FPN_RAMP_STEP_CYC   (((`FPN_RAMP_MS * 1000000) / `FPN_CLK_NS) / (`FPN_PW_MAX_CYC - `FPN_PW_MIN_CYC))

// field widths and positions
`define FPN_TMR_W           23
`define FPN_RAMP_W          16
`define FPN_OS_W            10
`define FPN_PW_W            7
`define FPN_TRY_W           4
`define FPN_HI_NIB_LSB      4
`define FPN_RANGE_MSB       11
`define FPN_RANGE_LSB       8

`endif

// ### common/fpn_pkg.sv
// fpn_pkg.sv - types of the fuse nibble programmer: operations, outcomes, states.
// assumes fpn_consts.svh is found on the include path.
package fpn_pkg;
	`include "fpn_consts.svh"

	typedef enum logic [1:0] {OP_READ, OP_PROG_HI, OP_PROG_LO, OP_NONE} fpn_op_type;
	typedef enum logic [1:0] {RES_OK, RES_ADDR_ERR, RES_CONFLICT, RES_NO_PROG} fpn_res_type;
	typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_READ, ST_CMP, ST_BURN, ST_PAUSE} fpn_st_type;

	// whole register state of the programmer
	typedef struct packed {
		fpn_st_type              st;
		fpn_op_type              op;
		logic [1:0]              idx;
		logic [`FPN_TRY_W-1:0]   tries;
		logic                    phase;
		logic                    pon;
		logic [`FPN_PW_W-1:0]    width;
		logic [`FPN_PW_W-1:0]    pcnt;
		logic [`FPN_RAMP_W-1:0]  rcnt;
		logic [`FPN_TMR_W-1:0]   tmr;
		logic                    sense_q;
		logic                    armed;
		logic                    fired;
		logic [`FPN_OS_W-1:0]    os_cnt;
		logic [7:0]              rd_data_n;
		fpn_res_type             res;
		logic                    done;
	} fpn_state_type;
endpackage : fpn_pkg

// ### dv/fpn_prom_model.sv
// fpn_prom_model.sv - behavioural 256x4 fuse prom standing behind the socket.
// assumes the programmer drives the socket pins synchronously to clk.
`timescale 1ns/1ps
module fpn_prom_model #(
	parameter int BLOW_PULSES = 3
) (
	// clock
	input  wire logic       clk,
	// socket pins
	input  wire logic [7:0] socket_addr,
	input  wire logic [3:0] drive_bits,
	input  wire logic       pulse_supply,
	input  wire logic       program_phase,
	output logic [3:0]      prom_dout,
	// fault control from the bench
	input  wire logic       stubborn
);
	logic [3:0] mem [256];
	int         hits [4];
	logic       pulse_q = 1'b0;

	// a fuse needs several pulses, so the sense sees intact lows first;
	// a stubborn part never blows and forces the retry path
	always @(posedge clk) begin
		pulse_q <= pulse_supply;
		for (int b = 0; b < 4; b++) begin
			if (!program_phase)
				hits[b] <= 0;
			else if (pulse_supply && !pulse_q && drive_bits[b] && !stubborn) begin
				hits[b] <= hits[b] + 1;
				if (hits[b] + 1 >= BLOW_PULSES)
					mem[socket_addr][b] <= 1'b1;
			end
		end
	end

	// outputs follow the addressed word at once
	assign prom_dout = mem[socket_addr];
endmodule : fpn_prom_model

// ### dv/tb_top.sv
// tb_top.sv - self-checking bench of the fuse nibble programmer with a prom model.
// assumes shortened burn timeout and pause; the one-shot keeps 1000 cycles.
`timescale 1ns/1ps
module tb_top;
	import fpn_pkg::*;
	localparam int TMO = 3000;
	logic        clk = 0, rst_b = 0, op_start = 0, stubborn = 0;
	fpn_op_type  op_kind = OP_NONE, cur_op = OP_NONE;
	logic [11:0] prom_addr = 0;
	logic [7:0]  write_data = 0, read_data_n, socket_addr;
	logic        busy, op_done, range_fault, write_bit_n, program_phase, fuse_sense;
	logic        burn_done_n, pulse_supply, chip_disable_pulse;
	fpn_res_type outcome;
	logic [1:0]  bit_index;
	logic [3:0]  bit_position, prom_dout, drive_bits;
	int          err_total = 0, n_checks = 0, n_rise = 0, hi_len = 0, quiet = 0;
	logic        ph_q = 0, pu_q = 0, bd_q = 1, se_q = 0, first_pw = 0;

	fpn_programmer #(.BURN_TMO_CYC(TMO), .PAUSE_CYC(5), .RAMP_STEP_CYC(3)) u_dut (
		.clk, .rst_b, .op_start, .op_kind, .prom_addr, .write_data, .busy, .op_done,
		.outcome, .read_data_n, .range_fault, .write_bit_n, .bit_index, .bit_position,
		.program_phase, .fuse_sense, .burn_done_n, .socket_addr, .prom_dout,
		.pulse_supply, .chip_disable_pulse, .drive_bits);
	fpn_prom_model #(.BLOW_PULSES(3)) u_prom (
		.clk, .socket_addr, .drive_bits, .pulse_supply, .program_phase, .prom_dout, .stubborn);

	// 10 MHz clock
	always #50 clk = ~clk;

	task automatic chk1(input logic got, input logic exp, input string m);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t %s", $time, m);
		end
	endtask : chk1

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk8

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	// one request, then a bounded wait for the done pulse
	task automatic run_op(input fpn_op_type k, input logic [11:0] a, input logic [7:0] w);
		int n;
		n_rise = 0;
		@(posedge clk);
		op_start <= 1'b1;
		op_kind <= k;
		prom_addr <= a;
		write_data <= w;
		@(posedge clk);
		op_start <= 1'b0;
		cur_op <= k;
		for (n = 0; n < 40000 && op_done !== 1'b1; n++)
			@(negedge clk);
		if (n == 40000) begin
			err_total++;
			tally_and_finish();
		end
	endtask : run_op

	// expected outcome, burn count and final word of a program request
	function automatic fpn_res_type exp_prog(input logic [3:0] old, input logic [3:0] want,
			output int burns, output logic [3:0] fin);
		burns = 0;
		fin = old;
		for (int i = 0; i < 4; i++)
			if (want[i] && !old[i]) begin
				burns++;
				fin[i] = 1'b1;
			end else if (!want[i] && old[i])
				return RES_CONFLICT;
		return RES_OK;
	endfunction : exp_prog

	// port monitor, sampled mid-cycle where everything has settled
	always @(negedge clk) if (rst_b) begin
		chk1(range_fault, prom_addr[11:8] != 4'h0, "range fault");
		chk8(socket_addr, prom_addr[7:0], "socket address");
		chk8(bit_position, 8'h1 << bit_index, "position decode");
		chk8(drive_bits, (program_phase && pulse_supply) ? bit_position : 4'h0, "drive");
		chk1(chip_disable_pulse, pulse_supply, "chip disable");
		if (busy && cur_op != OP_READ)
			chk1(write_bit_n, ~write_data[{cur_op == OP_PROG_HI, bit_index}], "wbit");
		if (!program_phase)
			chk1(fuse_sense, prom_dout[bit_index], "read sense");
		else if (prom_dout[bit_index])
			chk1(fuse_sense, 1'b0, "blown sense");
		if (!program_phase)
			chk1(burn_done_n, 1'b1, "done idle");
		if (!bd_q)
			chk1(program_phase, 1'b0, "phase drop");
		quiet = (fuse_sense && !se_q) ? 0 : quiet + 1;
		if (!burn_done_n && bd_q)
			chk1(quiet >= 999 && quiet <= 1001, 1'b1, "one-shot time");
		if (program_phase && !ph_q) begin
			n_rise++;
			first_pw = 1'b1;
		end
		// a pulse cut short by the end of the phase is no full pulse
		if (!pulse_supply && pu_q && program_phase) begin
			if (first_pw)
				chk8(hi_len[7:0], 8'd10, "first width");
			else
				chk1(hi_len >= 10 && hi_len <= 80, 1'b1, "width span");
			first_pw = 1'b0;
		end
		hi_len = pulse_supply ? hi_len + 1 : 0;
		ph_q = program_phase;
		pu_q = pulse_supply;
		bd_q = burn_done_n;
		se_q = fuse_sense;
	end else begin
		// history restarts with reset so no false edge follows its release
		ph_q = 1'b0;
		pu_q = 1'b0;
		bd_q = 1'b1;
		se_q = 1'b0;
		hi_len = 0;
		first_pw = 1'b0;
	end

	initial begin
		int          b;
		logic [3:0]  w, fin, old;
		logic [11:0] a;
		logic [7:0]  d;
		fpn_op_type  k;
		fpn_res_type r;
		void'($urandom(32'hbfd27828));
		for (int i = 0; i < 256; i++)
			u_prom.mem[i] = 4'($urandom);
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		chk8(read_data_n, 8'hff, "reset read data");
		chk8({busy, op_done, program_phase, burn_done_n}, 8'h1, "reset flags");
		// every entry point refused above the last word
		for (int j = 0; j < 3; j++) begin
			run_op(fpn_op_type'(j), 12'h100 << j, 8'hff);
			chk8(outcome, RES_ADDR_ERR, "address error");
			chk8(n_rise[7:0], 8'h0, "no burn on abort");
		end
		// random reads and programs; bit 0 conflict as a corner case
		for (int t = 0; t < 24; t++) begin
			k = fpn_op_type'(t % 3);
			a = 12'($urandom);
			d = 8'($urandom);
			if ($urandom_range(3) != 0 || t == 2)
				a[11:8] = 4'h0;
			if (t == 2)
				d = 8'h0e;
			if (t == 2)
				u_prom.mem[a[7:0]] = 4'hf;
			old = u_prom.mem[a[7:0]];
			w = (k == OP_PROG_HI) ? d[7:4] : d[3:0];
			r = exp_prog(old, w, b, fin);
			run_op(k, a, d);
			if (a[11:8] != 4'h0)
				chk8(outcome, RES_ADDR_ERR, "range abort");
			else if (k == OP_READ) begin
				chk8(read_data_n, {~old, ~old}, "read word");
				chk8(outcome, RES_OK, "read outcome");
			end else begin
				chk8(outcome, r, "program outcome");
				chk8(n_rise[7:0], b[7:0], "burn count");
				chk8(u_prom.mem[a[7:0]], fin, "fused word");
			end
		end
		// unknown code refused; a burn ignores a new start and stops on reset
		@(posedge clk);
		op_start <= 1'b1;
		op_kind <= OP_NONE;
		@(posedge clk);
		op_start <= 1'b0;
		@(negedge clk);
		chk1(busy, 1'b0, "unknown op ignored");
		u_prom.mem[8'h10] = 4'h0;
		@(posedge clk);
		op_start <= 1'b1;
		op_kind <= OP_PROG_LO;
		prom_addr <= 12'h010;
		write_data <= 8'h01;
		cur_op <= OP_PROG_LO;
		@(posedge clk);
		op_start <= 1'b0;
		repeat (20) @(posedge clk);
		op_start <= 1'b1;
		op_kind <= OP_READ;
		@(posedge clk);
		op_start <= 1'b0;
		@(negedge clk);
		chk1(program_phase, 1'b1, "start ignored while busy");
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		chk8({busy, op_done, program_phase, burn_done_n, drive_bits}, 8'h10, "mid-run reset");
		chk8(read_data_n, 8'hff, "mid-run reset read data");
		// a fuse that never blows runs out of retries
		stubborn <= 1'b1;
		u_prom.mem[8'h42] = 4'h0;
		run_op(OP_PROG_LO, 12'h042, 8'h01);
		chk8(outcome, RES_NO_PROG, "no program");
		chk8(n_rise[7:0], 8'h8, "retries");
		tally_and_finish();
	end
endmodule : tb_top
